// ==== design/path_initializing_state_top.sv ====
// Purpose: data path configuration and initialization sequencer
// Assumes: host keeps its sequence; single data path state for all lanes
// Notes: flags clear on read; interrupt status clears by writing one
// Overview of operation
// - on a trigger the staged code is checked and copied to the active set only if valid.
// - init-pending bits are updated before the result status fields.
// - when the deinit condition goes false the path enters initializing.
// - while initializing the path resources are set up, then pending bits clear.
// - entry into initialized sets the state-changed flags and the interrupt.
// - reading the flag register clears the latched flags.
`timescale 1ns/100ps
module path_initializing_state_top
  import path_initializing_state_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire path_initializing_state_pkg::path_initializing_state_bus_req_t bus_req,
  output logic [31:0] rdata,
  output logic irq
);
  import path_initializing_state_pkg::*;

  logic [app_w-1:0] staged_app_r [lanes];
  logic [app_w-1:0] active_app_r [lanes];
  logic [lanes-1:0] deinit_r;
  logic [lanes-1:0] pend_r;
  logic [lanes-1:0] trig_r;
  logic [1:0] status_r [lanes];
  logic [lanes-1:0] flag_r;
  logic [1:0] irq_stat_r;
  logic [1:0] irq_mask_r;
  logic [lanes-1:0] init_lanes_r;
  logic [7:0] cnt_r;
  logic cfg_stage_r;
  path_initializing_state_state_t state_r;
  logic wr_hit;
  logic rd_hit;
  logic [lanes-1:0] lane_valid;
  logic [lanes-1:0] cond_false;
  logic init_done;
  logic [1:0] irq_evt;

  assign wr_hit = bus_req.wr;
  assign rd_hit = bus_req.rd;

  always_comb begin
    for (int i = 0; i < lanes; i++) begin
      lane_valid[i] = supported_apps[staged_app_r[i]];
    end
  end

  // staged code writes, one nibble per lane
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < lanes; i++) begin
        staged_app_r[i] <= app_code_reset;
      end
    end else if (wr_hit && bus_req.addr == off_app_select) begin
      for (int i = 0; i < lanes; i++) begin
        staged_app_r[i] <= bus_req.wdata[i*app_w +: app_w];
      end
    end
  end

  // trigger latch held for the two-step update
  always_ff @(posedge clk) begin
    if (srst) begin
      trig_r <= '0;
      cfg_stage_r <= 1'b0;
    end else if (cfg_stage_r) begin
      cfg_stage_r <= 1'b0;
      trig_r <= '0;
    end else if (wr_hit && bus_req.addr == off_apply_trig && bus_req.wdata[lanes-1:0] != '0) begin
      trig_r <= bus_req.wdata[lanes-1:0];
      cfg_stage_r <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < lanes; i++) begin
        active_app_r[i] <= app_code_reset;
      end
    end else if (wr_hit && bus_req.addr == off_apply_trig && !cfg_stage_r) begin
      for (int i = 0; i < lanes; i++) begin
        if (bus_req.wdata[i] && lane_valid[i]) begin
          active_app_r[i] <= staged_app_r[i];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      deinit_r <= deinit_reset;
    end else if (wr_hit && bus_req.addr == off_deinit_req) begin
      deinit_r <= bus_req.wdata[lanes-1:0];
    end
  end

  // pending clears after init
  // a trigger landing on the init_done cycle must not lose its pending bits
  always_ff @(posedge clk) begin
    if (srst) begin
      pend_r <= '0;
    end else begin
      pend_r <= (init_done ? (pend_r & ~init_lanes_r) : pend_r)
                | ((wr_hit && bus_req.addr == off_apply_trig && !cfg_stage_r) ?
                   (bus_req.wdata[lanes-1:0] & lane_valid) : '0);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < lanes; i++) begin
        status_r[i] <= cfg_undefined;
      end
    end else if (cfg_stage_r) begin
      for (int i = 0; i < lanes; i++) begin
        if (trig_r[i]) begin
          status_r[i] <= lane_valid[i] ? cfg_accepted : cfg_rejected;
        end
      end
    end
  end

  // pending lanes whose deinit went low
  assign cond_false = pend_r & ~deinit_r;
  // fixed resource setup time stands in for analog bring-up
  assign init_done = (state_r == path_initializing_state_init_s) && (cnt_r == 8'(init_cycles - 1));

  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= path_initializing_state_deact_s;
      cnt_r <= 8'h00;
      init_lanes_r <= '0;
    end else begin
      unique case (state_r)
        path_initializing_state_deact_s, path_initializing_state_done_s: begin
          if (cond_false != '0 && !cfg_stage_r) begin
            state_r <= path_initializing_state_init_s;
            init_lanes_r <= cond_false;
            cnt_r <= 8'h00;
          end
        end
        path_initializing_state_init_s: begin
          cnt_r <= cnt_r + 8'h01;
          if (init_done) begin
            state_r <= path_initializing_state_done_s;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      flag_r <= '0;
    end else begin
      flag_r <= ((rd_hit && bus_req.addr == off_state_flag) ? '0 : flag_r) | (init_done ? init_lanes_r : '0);
    end
  end

  assign irq_evt = {init_done, cfg_stage_r};

  // sticky status, write one clears, set wins
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_stat_r <= 2'h0;
      irq_mask_r <= mask_reset[1:0];
    end else begin
      irq_stat_r <= (irq_stat_r & ~((wr_hit && bus_req.addr == off_irq_status) ? bus_req.wdata[1:0] : 2'h0))
                    | irq_evt;
      if (wr_hit && bus_req.addr == off_irq_mask) begin
        irq_mask_r <= bus_req.wdata[1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= (|(irq_stat_r & irq_mask_r)) || (|flag_r);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= 32'h0000_0000;
      if (rd_hit) begin
        unique case (bus_req.addr)
          off_app_select: begin
            for (int i = 0; i < lanes; i++) rdata[i*app_w +: app_w] <= staged_app_r[i];
          end
          off_active_app: begin
            for (int i = 0; i < lanes; i++) rdata[i*app_w +: app_w] <= active_app_r[i];
          end
          off_cfg_status: begin
            for (int i = 0; i < lanes; i++) rdata[i*2 +: 2] <= status_r[i];
          end
          off_deinit_req: rdata[lanes-1:0] <= deinit_r;
          off_init_pend: rdata[lanes-1:0] <= pend_r;
          off_state_flag: rdata[lanes-1:0] <= flag_r;
          off_irq_status: rdata[1:0] <= irq_stat_r;
          off_irq_mask: rdata[1:0] <= irq_mask_r;
          off_path_state: rdata[1:0] <= state_r;
          off_supported: rdata[15:0] <= supported_apps;
          default: rdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

// ==== design/path_initializing_state_pkg.sv ====
// Purpose: constants and types for the data path init sequencer
// Assumes: eight host lanes, one register bus of 32-bit words
// Notes: offsets are word-aligned byte addresses
package path_initializing_state_pkg;
  localparam int unsigned lanes = 8;
  localparam logic [7:0] off_app_select = 8'h00;
  localparam logic [7:0] off_apply_trig = 8'h04;
  localparam logic [7:0] off_deinit_req = 8'h08;
  localparam logic [7:0] off_active_app = 8'h0c;
  localparam logic [7:0] off_init_pend = 8'h10;
  localparam logic [7:0] off_cfg_status = 8'h14;
  localparam logic [7:0] off_state_flag = 8'h18;
  localparam logic [7:0] off_irq_status = 8'h1c;
  localparam logic [7:0] off_irq_mask = 8'h20;
  localparam logic [7:0] off_path_state = 8'h24;
  localparam logic [7:0] off_supported = 8'h28;
  localparam logic [7:0] deinit_reset = 8'h00;
  localparam logic [7:0] mask_reset = 8'h00;
  localparam logic [3:0] app_code_reset = 4'h1;
  localparam logic [15:0] supported_apps = 16'h000e;
  localparam int unsigned app_w = 4;
  localparam int unsigned init_time_ns = 100;
  localparam int unsigned clk_period_ns = 5;
  localparam int unsigned init_cycles = (init_time_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int unsigned irq_evt_cfg = 0;
  localparam int unsigned irq_evt_init = 1;
  localparam logic [1:0] cfg_undefined = 2'h0;
  localparam logic [1:0] cfg_accepted = 2'h1;
  localparam logic [1:0] cfg_rejected = 2'h2;
  typedef enum logic [1:0] {
    path_initializing_state_deact_s = 2'b00,
    path_initializing_state_init_s = 2'b01,
    path_initializing_state_done_s = 2'b11
  } path_initializing_state_state_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } path_initializing_state_bus_req_t;
endpackage

// ==== test/path_initializing_state_monitor.sv ====
// Purpose: port-level checks for path_initializing_state_top
// Assumes: one clock, sync reset, no bus waits
// Notes: register contents are seen through reads only
`timescale 1ns/100ps
module path_initializing_state_monitor
  import path_initializing_state_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire path_initializing_state_pkg::path_initializing_state_bus_req_t bus_req,
  input wire logic [31:0] rdata,
  input wire logic irq
);
  logic act_ok, st_ok;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  always_comb begin
    act_ok = 1'b1;
    st_ok = 1'b1;
    for (int i = 0; i < lanes; i++) begin
      act_ok = act_ok & supported_apps[rdata[4*i +: 4]];
      st_ok = st_ok & (rdata[2*i +: 2] != 2'h3);
    end
  end
  sequence rd_of(logic [7:0] a);
    bus_req.rd && bus_req.addr == a;
  endsequence
  chk_active_code_ok: assert property (rd_of(off_active_app) |=> act_ok)
    else $error("unsupported active code");
  chk_status_code_ok: assert property (rd_of(off_cfg_status) |=> st_ok)
    else $error("illegal status code");
  chk_path_state_ok: assert property (rd_of(off_path_state) |=> rdata inside {32'h0, 32'h1, 32'h3})
    else $error("illegal path state");
  chk_ready_no_pend: assert property (
    rd_of(off_path_state) ##1 (rd_of(off_init_pend) && rdata == 32'h3) |=> rdata[7:0] == 8'h00)
    else $error("pending left after init");
  chk_flag_raises_irq: assert property (rd_of(off_state_flag) ##1 (rdata[7:0] != 8'h00) |-> irq)
    else $error("flag set without irq");
  chk_flag_read_clr: assert property (rd_of(off_state_flag) ##1 rd_of(off_state_flag) |=> rdata[7:0] == 8'h00)
    else $error("flags survive a read");
endmodule
bind path_initializing_state_top path_initializing_state_monitor mon_u (.clk(clk), .srst(srst), .bus_req(bus_req), .rdata(rdata), .irq(irq));

// ==== test/path_initializing_state_host_model.sv ====
// Purpose: host side bus driver for path_initializing_state_top
// Assumes: slave never stalls
// Notes: strobe holds until the next call, so calls run back to back
`timescale 1ns/100ps
module path_initializing_state_host_model
  import path_initializing_state_pkg::*;
(
  input wire logic clk,
  output path_initializing_state_pkg::path_initializing_state_bus_req_t bus_req
);
  initial bus_req = '0;
  task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: w, rd: r};
  endtask
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk);
      bus_req <= '0;
    end
  endtask
endmodule

// ==== test/path_initializing_state_top_tb.sv ====
// Purpose: register-level sequence test of path_initializing_state_top
// Assumes: default package constants
// Notes: read data compared at the falling edge after the read
`timescale 1ns/100ps
module path_initializing_state_top_tb;
  import path_initializing_state_pkg::*;
  logic clk, srst, irq, take_r;
  path_initializing_state_bus_req_t bus_req;
  logic [31:0] rdata, exp_r, exp_nx;
  int fail_count, compares, i;
  path_initializing_state_top dut_u (.clk(clk), .srst(srst), .bus_req(bus_req), .rdata(rdata), .irq(irq));
  path_initializing_state_host_model host_u (.clk(clk), .bus_req(bus_req));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_u.op(1'b1, 1'b0, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    host_u.op(1'b0, 1'b1, a, 32'h0);
    exp_nx <= e;
  endtask
  // bounded wait, a miss ends the run
  task automatic wait_irq(input logic lvl);
    host_u.idle(1);
    @(negedge clk);
    for (i = 0; i < 40 && irq !== lvl; i++) @(negedge clk);
    chk({31'h0, irq}, {31'h0, lvl});
    if (irq !== lvl) complete_run();
  endtask
  always @(posedge clk) begin
    take_r <= bus_req.rd;
    exp_r <= exp_nx;
  end
  always @(negedge clk) begin
    if (take_r === 1'b1) chk(rdata, exp_r);
  end
  initial begin
    srst = 1'b1;
    exp_nx = 32'h0;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    rd(off_deinit_req, {24'h0, deinit_reset});
    rd(off_active_app, 32'h11111111);
    rd(off_path_state, 32'h0);
    rd(off_supported, 32'h0000000e);
    rd(8'h3c, 32'h0);
    wr(off_deinit_req, 32'hff);
    wr(off_irq_mask, 32'h1);
    wr(off_app_select, 32'h11112222);
    rd(off_app_select, 32'h11112222);
    wr(off_apply_trig, 32'h0f);
    rd(off_cfg_status, 32'h0);
    rd(off_init_pend, 32'h0f);
    rd(off_cfg_status, 32'h55);
    rd(off_active_app, 32'h11112222);
    rd(off_irq_status, 32'h1);
    wait_irq(1'b1);
    wr(off_irq_status, 32'h1);
    wr(off_irq_mask, 32'h0);
    wait_irq(1'b0);
    // an all-zero trigger is ignored, so no config event
    wr(off_apply_trig, 32'h00);
    host_u.idle(2);
    rd(off_irq_status, 32'h0);
    // unsupported code on lane 4 must bounce; the trigger right behind it is refused
    wr(off_app_select, 32'h11152222);
    wr(off_apply_trig, 32'h10);
    wr(off_apply_trig, 32'h20);
    host_u.idle(2);
    rd(off_cfg_status, 32'h255);
    rd(off_active_app, 32'h11112222);
    rd(off_init_pend, 32'h0f);
    rd(off_cfg_status, 32'h255);
    rd(off_deinit_req, 32'hff);
    wr(off_deinit_req, 32'hf0);
    host_u.idle(3);
    rd(off_path_state, 32'h1);
    wait_irq(1'b1);
    rd(off_path_state, 32'h3);
    rd(off_init_pend, 32'h0);
    rd(off_irq_status, 32'h3);
    rd(off_state_flag, 32'h0f);
    rd(off_state_flag, 32'h0);
    wait_irq(1'b0);
    host_u.idle(2);
    // mid-run reset must bring back the power-on values
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd(off_deinit_req, {24'h0, deinit_reset});
    rd(off_path_state, 32'h0);
    rd(off_active_app, 32'h11111111);
    rd(off_cfg_status, 32'h0);
    rd(off_state_flag, 32'h0);
    wait_irq(1'b0);
    host_u.idle(2);
    complete_run();
  end
endmodule
